// ==== fail_safe_regs.vh ====
// Register map, field positions and timing constants of the fail-safe and power control block
//
// Summary of operation
// - Watchdog is a 15-bit up-counter counting at clock/12 or clock/192.
// - Watchdog count rate comes from a divide-by-two then divide-by-16 prescaler cascade.
// - Only the top 7 watchdog bits are loadable; lower bits are not writable.
// - Software start bit starts the watchdog; software cannot stop it, only an internal or external reset does.
// - Watchdog overflow without refresh triggers an internal reset.
// - A valid refresh copies the reload value into the top 7 counter bits.
// - Readable flag tells whether last reset came from watchdog or external pin.
// - Watchdog holds its value while in idle or power-down.
// - Main oscillator slower than RC: switch clock to RC and hold reset.
// - Main faster again: extend reset about 1 ms, then restart from address zero.
// - After power-on, reset runs on RC clock until main oscillator compares good.
// - Power-down stops both oscillators; leaving power-down restarts both.
// - After wake-up wait for main good plus 1 ms, then signal wake interrupt.
// - Low pulse on external interrupt 0 or CAN receive pin ends power-down.
// - Idle gates the CPU clock; oscillator and peripheral clocks keep running.
// - Idle ends on an enabled peripheral interrupt or a hardware reset.
// - Idle entry: write 01h then 20h to the power control register.
// - Power-down entry: write 02h then 40h; state is retained meanwhile.
// - Slow-down divides CPU and peripheral clock by 32; combines with idle.
// - Bit 10h enters slow-down; clearing it or hardware reset ends it.
`ifndef FAIL_SAFE_REGS_VH
`define FAIL_SAFE_REGS_VH
// ****************************************
// Register byte addresses
// ****************************************
`define PWR_CTRL_ADDR 8'h00
`define WDOG_CTRL_ADDR 8'h04
`define WDOG_RELOAD_ADDR 8'h08
`define STATUS_ADDR 8'h0c
// ****************************************
// Field positions
// ****************************************
`define PC_IDLE_ARM 0
`define PC_PD_ARM 1
`define PC_SLOW 4
`define PC_IDLE_SET 5
`define PC_PD_SET 6
`define WD_START 0
`define WD_ARM 1
`define WD_RUNNING 2
`define WD_CAUSE 3
`define WR_PRESC 7
`define WR_W 7
`define WDOG_W 15
`define ST_PSTATE 16
`define ST_SSTATE 18
`define ST_MAIN_GOOD 20
// ****************************************
// Dividers and timing
// ****************************************
`define CYC_DIV 6'h06
`define PRE1_DIV 6'h02
`define PRE2_DIV 6'h10
`define SLOW_DIV 6'h20
`define CMP_WIN 6'h10
`define SETTLE_MS 16'h0001
`define CLK_KHZ 16'h9c40
`define HTRANS_NONSEQ 2'b10
`endif

// ==== fail_safe_power_control.v ====
// Watchdog, oscillator supervisor and power saving control with an AHB-Lite register slave
`timescale 1ns/1ps
`include "fail_safe_regs.vh"

module fail_safe_power_control #(
  parameter [15:0] P_SETTLE_CYCLES = `SETTLE_MS * `CLK_KHZ
) (
  input wire I_CLK,
  input wire I_ARST_N,
  input wire I_HSEL,
  input wire [31:0] I_HADDR,
  input wire [1:0] I_HTRANS,
  input wire I_HWRITE,
  input wire [2:0] I_HSIZE,
  input wire [31:0] I_HWDATA,
  input wire I_HREADY,
  output reg [31:0] O_HRDATA,
  output reg O_HREADYOUT,
  output reg O_HRESP,
  input wire I_MAIN_TICK,
  input wire I_RC_TICK,
  input wire I_EXT_IRQ0_N,
  input wire I_CAN_RX_N,
  input wire I_PERIPH_IRQ,
  output reg O_SYS_RST,
  output reg O_CLK_SEL_RC,
  output reg O_OSC_EN,
  output reg O_CPU_CLK_EN,
  output reg O_PERIPH_CLK_EN,
  output reg O_WAKE_IRQ
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] P_ACT = 2'h0;
  localparam [1:0] P_IDLE = 2'h1;
  localparam [1:0] P_PD = 2'h2;
  localparam [1:0] P_WAKE = 2'h3;
  localparam [1:0] S_FAIL = 2'h0;
  localparam [1:0] S_EXT = 2'h1;
  localparam [1:0] S_OK = 2'h2;
  localparam [15:0] SETTLE_LAST = P_SETTLE_CYCLES - 16'h0001;

  // Divider wrap test shared by all prescalers
  function last_cnt;
    input [4:0] cnt;
    input [5:0] div;
    begin
      last_cnt = ({1'b0, cnt} == (div - 6'h01));
    end
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  reg dp_wr_q;
  reg dp_act_q;
  reg [7:0] dp_addr_q;
  wire addr_ph = I_HSEL & I_HREADY & I_HTRANS[1];
  wire wr_pc = dp_wr_q & (dp_addr_q == `PWR_CTRL_ADDR);
  wire wr_wc = dp_wr_q & (dp_addr_q == `WDOG_CTRL_ADDR);
  wire wr_wr = dp_wr_q & (dp_addr_q == `WDOG_RELOAD_ADDR);

  reg [1:0] pstate_q;
  reg [1:0] sstate_q;
  reg slow_q;
  reg idle_arm_q;
  reg pd_arm_q;
  reg wd_arm_q;
  reg wd_run_q;
  reg wd_cause_q;
  reg [`WR_W-1:0] wd_reload_q;
  reg wd_presc_q;
  reg [`WDOG_W-1:0] wd_cnt_q;
  reg main_good_q;
  reg [31:0] rdata;

  // Read mux, sampled at the address phase so data stand in the data phase
  always @* begin
    rdata = 32'h00000000;
    case (I_HADDR[7:0])
      `PWR_CTRL_ADDR: begin
        rdata[`PC_SLOW] = slow_q;
      end
      `WDOG_CTRL_ADDR: begin
        rdata[`WD_RUNNING] = wd_run_q;
        rdata[`WD_CAUSE] = wd_cause_q;
      end
      `WDOG_RELOAD_ADDR: begin
        rdata[`WR_W-1:0] = wd_reload_q;
        rdata[`WR_PRESC] = wd_presc_q;
      end
      `STATUS_ADDR: begin
        rdata[`WDOG_W-1:0] = wd_cnt_q;
        rdata[`ST_PSTATE+1:`ST_PSTATE] = pstate_q;
        rdata[`ST_SSTATE+1:`ST_SSTATE] = sstate_q;
        rdata[`ST_MAIN_GOOD] = main_good_q;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

  // Zero wait state slave, always OKAY; unmapped reads return zero
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      dp_wr_q <= 1'b0;
      dp_act_q <= 1'b0;
      dp_addr_q <= 8'h00;
      O_HRDATA <= 32'h00000000;
      O_HREADYOUT <= 1'b0;
      O_HRESP <= 1'b0;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
      dp_act_q <= addr_ph;
      dp_wr_q <= addr_ph & I_HWRITE;
      if (addr_ph) begin
        dp_addr_q <= I_HADDR[7:0];
        O_HRDATA <= rdata;
      end
    end
  end

  // ****************************************
  // Oscillator comparison
  // ****************************************
  reg [4:0] rc_win_q;
  reg [4:0] main_cnt_q;
  wire osc_run = (pstate_q != P_PD);
  wire win_end = I_RC_TICK & last_cnt(rc_win_q, `CMP_WIN);

  // Count main ticks over a window of RC ticks; main must outpace RC
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rc_win_q <= 5'h00;
      main_cnt_q <= 5'h00;
      main_good_q <= 1'b0;
    end else if (!osc_run) begin
      rc_win_q <= 5'h00;
      main_cnt_q <= 5'h00;
      main_good_q <= 1'b0;
    end else begin
      if (I_RC_TICK) begin
        rc_win_q <= win_end ? 5'h00 : rc_win_q + 5'h01;
      end
      if (win_end) begin
        main_good_q <= (main_cnt_q > `CMP_WIN);
        main_cnt_q <= 5'h00;
      end else if (I_MAIN_TICK && (main_cnt_q != 5'h1f)) begin
        main_cnt_q <= main_cnt_q + 5'h01; // Saturates so a fast crystal cannot wrap
      end
    end
  end

  // ****************************************
  // Supervisor and settle timer
  // ****************************************
  reg [15:0] settle_q;
  wire settle_done = (settle_q == SETTLE_LAST);
  wire sup_hold = (pstate_q == P_PD) || (pstate_q == P_WAKE);
  wire wake_wait = (pstate_q == P_WAKE) & main_good_q;

  // Held in S_OK during power-down and wake, where the oscillator is slow by design; settle_q counts only in S_EXT and, in S_OK, in wake
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sstate_q <= S_FAIL;
      settle_q <= 16'h0000;
    end else begin
      case (sstate_q)
        S_FAIL: begin
          settle_q <= 16'h0000;
          if (main_good_q) begin
            sstate_q <= S_EXT;
          end
        end
        S_EXT: begin
          if (!main_good_q) begin
            sstate_q <= S_FAIL;
            settle_q <= 16'h0000;
          end else if (settle_done) begin
            sstate_q <= S_OK;
            settle_q <= 16'h0000;
          end else begin
            settle_q <= settle_q + 16'h0001;
          end
        end
        S_OK: begin
          if (!sup_hold && !main_good_q) begin
            sstate_q <= S_FAIL;
          end else if (wake_wait) begin
            settle_q <= settle_done ? 16'h0000 : settle_q + 16'h0001;
          end else begin
            settle_q <= 16'h0000;
          end
        end
        default: begin
          sstate_q <= S_FAIL;
          settle_q <= 16'h0000;
        end
      endcase
    end
  end

  // ****************************************
  // Slow-down divider
  // ****************************************
  reg [4:0] slow_cnt_q;
  wire sys_en = !slow_q | last_cnt(slow_cnt_q, `SLOW_DIV);

  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      slow_cnt_q <= 5'h00;
    end else if (!slow_q || sys_en) begin
      slow_cnt_q <= 5'h00;
    end else begin
      slow_cnt_q <= slow_cnt_q + 5'h01;
    end
  end

  // ****************************************
  // Watchdog prescaler
  // ****************************************
  reg [2:0] cyc_q;
  reg pre1_q;
  reg [3:0] pre2_q;
  wire wd_halt = (pstate_q == P_IDLE) || (pstate_q == P_PD) || (pstate_q == P_WAKE);
  wire cyc_tick = sys_en & !wd_halt & last_cnt({2'b00, cyc_q}, `CYC_DIV);
  wire pre1_tick = cyc_tick & last_cnt({4'h0, pre1_q}, `PRE1_DIV);
  wire pre2_tick = pre1_tick & last_cnt({1'b0, pre2_q}, `PRE2_DIV);
  wire wd_tick = wd_run_q & (wd_presc_q ? pre2_tick : pre1_tick);
  wire int_rst = (sstate_q != S_OK);

  // Prescaler keeps its phase through halts so the period is not shortened
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      cyc_q <= 3'h0;
      pre1_q <= 1'b0;
      pre2_q <= 4'h0;
    end else if (sys_en && !wd_halt) begin
      cyc_q <= cyc_tick ? 3'h0 : cyc_q + 3'h1;
      if (cyc_tick) begin
        pre1_q <= ~pre1_q;
      end
      if (pre1_tick) begin
        pre2_q <= pre2_q + 4'h1;
      end
    end
  end

  // ****************************************
  // Watchdog counter and refresh
  // ****************************************
  wire wd_ovf = wd_tick & (&wd_cnt_q);
  wire refresh = wr_wc & I_HWDATA[`WD_START] & wd_arm_q & !I_HWDATA[`WD_ARM];

  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wd_cnt_q <= {`WDOG_W{1'b0}};
      wd_run_q <= 1'b0;
      wd_arm_q <= 1'b0;
      wd_reload_q <= {`WR_W{1'b0}};
      wd_presc_q <= 1'b0;
      wd_cause_q <= 1'b0;
    end else if (int_rst || wd_ovf) begin
      // Internal reset returns the watchdog to its power-up state, except the cause flag, which overflow sets
      wd_cnt_q <= {`WDOG_W{1'b0}};
      wd_run_q <= 1'b0;
      wd_arm_q <= 1'b0;
      wd_reload_q <= {`WR_W{1'b0}};
      wd_presc_q <= 1'b0;
      if (wd_ovf) begin
        wd_cause_q <= 1'b1;
      end
    end else begin
      if (dp_act_q) begin
        wd_arm_q <= wr_wc & I_HWDATA[`WD_ARM];
      end
      if (wr_wc && I_HWDATA[`WD_START]) begin
        wd_run_q <= 1'b1;
      end
      if (wr_wr) begin
        wd_reload_q <= I_HWDATA[`WR_W-1:0];
        wd_presc_q <= I_HWDATA[`WR_PRESC];
      end
      if (refresh) begin
        wd_cnt_q <= {wd_reload_q, {(`WDOG_W-`WR_W){1'b0}}};
      end else if (wd_tick) begin
        wd_cnt_q <= wd_cnt_q + {{(`WDOG_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Power mode control
  // ****************************************
  wire pin_wake = !I_EXT_IRQ0_N | !I_CAN_RX_N;
  wire go_idle = wr_pc & I_HWDATA[`PC_IDLE_SET] & idle_arm_q;
  wire go_pd = wr_pc & I_HWDATA[`PC_PD_SET] & pd_arm_q;

  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pstate_q <= P_ACT;
      slow_q <= 1'b0;
      idle_arm_q <= 1'b0;
      pd_arm_q <= 1'b0;
    end else if (int_rst || wd_ovf) begin
      pstate_q <= P_ACT;
      slow_q <= 1'b0;
      idle_arm_q <= 1'b0;
      pd_arm_q <= 1'b0;
    end else begin
      if (dp_act_q) begin
        idle_arm_q <= wr_pc & I_HWDATA[`PC_IDLE_ARM] & !I_HWDATA[`PC_IDLE_SET];
        pd_arm_q <= wr_pc & I_HWDATA[`PC_PD_ARM] & !I_HWDATA[`PC_PD_SET];
      end
      if (wr_pc) begin
        slow_q <= I_HWDATA[`PC_SLOW];
      end
      case (pstate_q)
        P_ACT: begin
          if (go_pd) begin
            pstate_q <= P_PD;
          end else if (go_idle) begin
            pstate_q <= P_IDLE;
          end
        end
        P_IDLE: begin
          if (I_PERIPH_IRQ) begin
            pstate_q <= P_ACT;
          end
        end
        P_PD: begin
          if (pin_wake) begin
            pstate_q <= P_WAKE;
          end
        end
        P_WAKE: begin
          if (wake_wait && settle_done) begin
            pstate_q <= P_ACT;
          end
        end
        default: begin
          pstate_q <= P_ACT;
        end
      endcase
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SYS_RST <= 1'b1;
      O_CLK_SEL_RC <= 1'b1;
      O_OSC_EN <= 1'b1;
      O_CPU_CLK_EN <= 1'b0;
      O_PERIPH_CLK_EN <= 1'b0;
      O_WAKE_IRQ <= 1'b0;
    end else begin
      O_SYS_RST <= int_rst | wd_ovf;
      O_CLK_SEL_RC <= (sstate_q == S_FAIL);
      O_OSC_EN <= osc_run;
      O_CPU_CLK_EN <= sys_en & (pstate_q == P_ACT);
      O_PERIPH_CLK_EN <= sys_en & ((pstate_q == P_ACT) || (pstate_q == P_IDLE));
      O_WAKE_IRQ <= wake_wait & settle_done;
    end
  end

endmodule // fail_safe_power_control

// ==== fsp_assertions.sv ====
// Port-level checker for the fail-safe and power control block
`timescale 1ns/1ps
module fsp_assertions #(
  parameter [15:0] P_SETTLE_CYCLES = 16'h9c40
) (
  input wire I_CLK,
  input wire I_ARST_N,
  input wire I_EXT_IRQ0_N,
  input wire I_CAN_RX_N,
  input wire I_PERIPH_IRQ,
  input wire O_SYS_RST,
  input wire O_CLK_SEL_RC,
  input wire O_OSC_EN,
  input wire O_CPU_CLK_EN,
  input wire O_PERIPH_CLK_EN,
  input wire O_WAKE_IRQ
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_ARST_N);
  // ****
  // Run lengths
  // ****
  logic [15:0] osc_q;
  logic [15:0] rst_q;
  // Saturating, so a long run never wraps to a small count
  always_ff @(posedge I_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      osc_q <= 16'h0000;
      rst_q <= 16'h0000;
    end else begin
      osc_q <= !O_OSC_EN ? 16'h0000 : osc_q + {15'h0000, osc_q != 16'hffff};
      rst_q <= !O_SYS_RST ? 16'h0000 : rst_q + {15'h0000, rst_q != 16'hffff};
    end
  end
  // ****
  // Properties
  // ****
  AST_OSC_OFF_GATED: assert property (!O_OSC_EN |-> !O_CPU_CLK_EN && !O_PERIPH_CLK_EN)
    else $error("clock enable with oscillators off");
  AST_PD_HOLDS: assert property ((!O_OSC_EN && I_EXT_IRQ0_N && I_CAN_RX_N) [*4] |=> !O_OSC_EN)
    else $error("power-down left without wake pin");
  AST_PD_WAKE: assert property (!O_OSC_EN && !(I_EXT_IRQ0_N && I_CAN_RX_N) |-> ##[1:3] O_OSC_EN)
    else $error("wake pin ignored in power-down");
  AST_IDLE_EXIT: assert property (O_PERIPH_CLK_EN && !O_CPU_CLK_EN && I_PERIPH_IRQ |-> ##[1:40] O_CPU_CLK_EN)
    else $error("idle not left on interrupt");
  AST_CPU_NEEDS_PERIPH: assert property (O_CPU_CLK_EN |-> O_PERIPH_CLK_EN)
    else $error("cpu clock without peripheral clock");
  AST_WAKE_PULSE: assert property (O_WAKE_IRQ |=> !O_WAKE_IRQ)
    else $error("wake request longer than one cycle");
  AST_WAKE_SETTLED: assert property (O_WAKE_IRQ |-> O_OSC_EN && !O_SYS_RST && osc_q >= P_SETTLE_CYCLES)
    else $error("wake request before settling");
  AST_RST_EXTEND: assert property ($fell(O_SYS_RST) |-> rst_q == 16'h0001 || rst_q >= P_SETTLE_CYCLES)
    else $error("reset released without extension");
  AST_MAIN_ON_RELEASE: assert property ($fell(O_SYS_RST) |-> ##[0:2] !O_CLK_SEL_RC)
    else $error("still on fallback clock after release");
  // Main scenarios reached
  cover property (O_WAKE_IRQ);
  cover property ($fell(O_SYS_RST) && rst_q == 16'h0001);
  cover property (O_PERIPH_CLK_EN && !O_CPU_CLK_EN && I_PERIPH_IRQ);
endmodule // fsp_assertions
bind fail_safe_power_control fsp_assertions #(.P_SETTLE_CYCLES(P_SETTLE_CYCLES)) chk_u (
  .I_CLK(I_CLK), .I_ARST_N(I_ARST_N), .I_EXT_IRQ0_N(I_EXT_IRQ0_N), .I_CAN_RX_N(I_CAN_RX_N),
  .I_PERIPH_IRQ(I_PERIPH_IRQ), .O_SYS_RST(O_SYS_RST), .O_CLK_SEL_RC(O_CLK_SEL_RC), .O_OSC_EN(O_OSC_EN),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_WAKE_IRQ(O_WAKE_IRQ));

// ==== testbench.sv ====
// Directed bus-level test of the fail-safe and power control block
`timescale 1ns/1ps
`include "fail_safe_regs.vh"
module testbench;
  localparam [15:0] SETTLE = 16'd20;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic mt = 1'b0;
  logic rt = 1'b0;
  logic irq0_n = 1'b1;
  logic can_n = 1'b1;
  logic per_irq = 1'b0;
  logic main_on = 1'b1;
  logic [1:0] ph = 2'b00;
  logic [31:0] r;
  logic [31:0] r2;
  logic [31:0] n;
  int err_count = 0;
  int comparisons = 0;
  int cyc = 0;
  wire [31:0] hrdata;
  wire hready, hresp, sys_rst, sel_rc, osc_en, cpu_en, per_en, wake;
  fail_safe_power_control #(.P_SETTLE_CYCLES(SETTLE)) dut_u (
    .I_CLK(clk), .I_ARST_N(arst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_MAIN_TICK(mt), .I_RC_TICK(rt), .I_EXT_IRQ0_N(irq0_n),
    .I_CAN_RX_N(can_n), .I_PERIPH_IRQ(per_irq), .O_SYS_RST(sys_rst), .O_CLK_SEL_RC(sel_rc),
    .O_OSC_EN(osc_en), .O_CPU_CLK_EN(cpu_en), .O_PERIPH_CLK_EN(per_en), .O_WAKE_IRQ(wake));
  // ****
  // Clock, oscillators, timeout
  // ****
  always #12.5 clk = ~clk;
  // Both oscillators stand still while stopped; main runs 4x the RC
  always @(posedge clk) begin
    ph <= ph + 2'b01;
    mt <= main_on & osc_en;
    rt <= (ph == 2'b11) & osc_en;
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      finish_test;
    end
  end
  // ****
  // Tasks
  // ****
  task finish_test;
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Single word transfer; read data taken at the data-phase edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  // Skips the edge that still carries the old mode, ends on a rising edge
  task rate(output logic [31:0] k);
    k = 32'h0;
    @(posedge clk);
    repeat (64) begin
      @(negedge clk);
      k = k + {31'h0, cpu_en};
    end
    @(posedge clk);
  endtask
  task leave_idle;
    per_irq <= 1'b1;
    repeat (3) @(posedge clk);
    per_irq <= 1'b0;
    repeat (2) @(negedge clk);
    chk("idle_exit", cpu_en, 1'b1);
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    repeat (15) @(posedge clk);
    @(negedge clk);
    chk("rst_out", {sys_rst, sel_rc, osc_en}, 3'b111);
    @(posedge clk);
    arst_n <= 1'b1;
    while (sys_rst !== 1'b0) @(posedge clk);
    bus(0, `STATUS_ADDR, 32'h0);
    chk("sup_ok", r[20:18], 3'b110);
    chk("hresp", hresp, 1'b0);
    // Slow-down on and off
    bus(1, `PWR_CTRL_ADDR, 32'h10);
    bus(0, `PWR_CTRL_ADDR, 32'h0);
    chk("slow_bit", r, 32'h10);
    rate(n);
    chk("slow_rate", n, 32'd2);
    bus(1, `PWR_CTRL_ADDR, 32'h0);
    rate(n);
    chk("full_rate", n, 32'd64);
    // A read between the two steps cancels idle entry
    bus(1, `PWR_CTRL_ADDR, 32'h1);
    bus(0, `PWR_CTRL_ADDR, 32'h0);
    bus(1, `PWR_CTRL_ADDR, 32'h20);
    bus(0, `STATUS_ADDR, 32'h0);
    chk("idle_cancel", r[17:16], 2'b00);
    // Power-down left through each wake pin
    for (int i = 0; i < 2; i++) begin
      bus(1, `PWR_CTRL_ADDR, 32'h2);
      bus(1, `PWR_CTRL_ADDR, 32'h40);
      repeat (20) @(negedge clk);
      chk("pd_osc", osc_en, 1'b0);
      @(posedge clk);
      if (i == 0) irq0_n <= 1'b0;
      else can_n <= 1'b0;
      @(posedge clk);
      irq0_n <= 1'b1;
      can_n <= 1'b1;
      while (wake !== 1'b1) @(posedge clk);
      bus(0, `STATUS_ADDR, 32'h0);
      chk("pd_exit", r[17:16], 2'b00);
    end
    // Watchdog: stop attempt, refresh, halt in idle, overflow
    bus(1, `WDOG_RELOAD_ADDR, 32'h7f);
    bus(1, `WDOG_CTRL_ADDR, 32'h1);
    bus(1, `WDOG_CTRL_ADDR, 32'h0);
    bus(0, `WDOG_CTRL_ADDR, 32'h0);
    chk("wd_run", r[2], 1'b1);
    bus(1, `WDOG_CTRL_ADDR, 32'h2);
    bus(1, `WDOG_CTRL_ADDR, 32'h1);
    bus(0, `STATUS_ADDR, 32'h0);
    chk("wd_load", r[14:8], 7'h7f);
    bus(1, `PWR_CTRL_ADDR, 32'h1);
    bus(1, `PWR_CTRL_ADDR, 32'h20);
    repeat (2) @(negedge clk);
    chk("idle_clk", {cpu_en, per_en}, 2'b01);
    @(posedge clk);
    bus(0, `STATUS_ADDR, 32'h0);
    r2 = r;
    repeat (100) @(posedge clk);
    bus(0, `STATUS_ADDR, 32'h0);
    chk("wd_halt", r[16:0], {2'b10, r2[14:0]});
    leave_idle;
    n = 32'h0;
    while (sys_rst !== 1'b1) begin
      @(posedge clk);
      n = n + 32'h1;
    end
    chk("wd_period", n > 32'd2900 && n <= 32'd3072, 1'b1);
    repeat (2) @(posedge clk);
    bus(0, `WDOG_CTRL_ADDR, 32'h0);
    chk("wd_cause", r[3:2], 2'b10);
    // Slow prescaler: exactly two ticks in 384 cycles
    bus(1, `WDOG_RELOAD_ADDR, 32'hff);
    bus(1, `WDOG_CTRL_ADDR, 32'h2);
    bus(1, `WDOG_CTRL_ADDR, 32'h1);
    bus(0, `STATUS_ADDR, 32'h0);
    r2 = r;
    repeat (382) @(posedge clk);
    bus(0, `STATUS_ADDR, 32'h0);
    chk("wd_slow_tick", r[14:0] - r2[14:0], 32'd2);
    // Main oscillator fails, then recovers
    main_on <= 1'b0;
    while (sys_rst !== 1'b1) @(posedge clk);
    repeat (2) @(negedge clk);
    chk("osc_fail", {sys_rst, sel_rc}, 2'b11);
    main_on <= 1'b1;
    // Extension counted from the end of the fallback phase
    while (sel_rc !== 1'b0) @(posedge clk);
    n = 32'h0;
    while (sys_rst !== 1'b0) begin
      @(posedge clk);
      n = n + 32'h1;
    end
    chk("extend", n >= SETTLE && n <= SETTLE + 16'd2, 1'b1);
    // External reset mid-run clears cause flag and slow-down
    bus(1, `PWR_CTRL_ADDR, 32'h10);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    while (sys_rst !== 1'b0) @(posedge clk);
    bus(0, `WDOG_CTRL_ADDR, 32'h0);
    chk("cause_ext", r[3:2], 2'b00);
    bus(0, `PWR_CTRL_ADDR, 32'h0);
    chk("slow_reset", r, 32'h0);
    finish_test;
  end
endmodule // testbench
